// file: hw/tbid_decoder.sv
// Instruction decoder and cycle sequencer for the twelve-bit core
module tbid_decoder
   import tbid_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              arst_n_in,
   input  wire logic [11:0]       instr_in,
   input  wire logic              zero_result_in,
   input  wire logic              tested_bit_in,
   input  wire logic              prescaler_on_timer_in,
   input  wire logic              file_is_port_in,
   output logic                   fetch_out,
   output logic [1:0]             phase_out,
   output logic                   cycle_end_out,
   output tbid_ctrl_s             ctrl_out,
   output tbid_fields_s           fields_out,
   output logic                   pc_bit8_clear_out,
   output logic [1:0]             load_direction_latch_port_out,
   output logic                   flush_out
);

   // ****************************************************************
   // Clock phases
   // ****************************************************************
   logic [1:0]   phase;
   logic         second_cycle;
   logic [11:0]  ir;
   logic         phase_wrap;
   logic         next_second;

   assign phase_wrap = (phase == PHASE_LAST);

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         phase <= 2'h0;
      else
         phase <= phase + 2'h1;
   end

   // ****************************************************************
   // Field split and opcode views
   // ****************************************************************
   tbid_fields_s fields;

   tbid_field_split u_split
   (
      .word_in    (ir),
      .fields_out (fields)
   );

   logic [5:0] byte_op;
   logic [3:0] nib_op;
   logic [2:0] br_op;

   assign byte_op = ir[BYTE_OP_HI:BYTE_OP_LO];
   assign nib_op  = ir[BIT_OP_HI:BIT_OP_LO];
   assign br_op   = ir[BRANCH_HI:BRANCH_LO];

   // ****************************************************************
   // Decode
   // ****************************************************************
   function automatic tbid_ctrl_s dec_word(input logic [11:0] w);
      tbid_ctrl_s c;
      logic [5:0] bo;
      logic [3:0] no;
      logic       d;
      c         = '0;
      c.alu_op  = ALU_PASS_F;
      c.pc_act  = PC_SEQ;
      bo        = w[BYTE_OP_HI:BYTE_OP_LO];
      no        = w[BIT_OP_HI:BIT_OP_LO];
      d         = w[DEST_POS];
      // Byte-oriented results follow the destination bit
      c.write_acc  = !d;
      c.write_file = d;
      unique case (bo)
         OP_ADD:   begin c.alu_op = ALU_ADD;  c.upd_c = 1'b1;
                   c.upd_dc = 1'b1; c.upd_z = 1'b1; end
         OP_SUB:   begin c.alu_op = ALU_SUB;  c.upd_c = 1'b1;
                   c.upd_dc = 1'b1; c.upd_z = 1'b1; end
         OP_AND:   begin c.alu_op = ALU_AND;  c.upd_z = 1'b1; end
         OP_OR:    begin c.alu_op = ALU_OR;   c.upd_z = 1'b1; end
         OP_XOR:   begin c.alu_op = ALU_XOR;  c.upd_z = 1'b1; end
         OP_COM:   begin c.alu_op = ALU_COM;  c.upd_z = 1'b1; end
         OP_DEC:   begin c.alu_op = ALU_DEC;  c.upd_z = 1'b1; end
         OP_INC:   begin c.alu_op = ALU_INC;  c.upd_z = 1'b1; end
         OP_MOV:   begin c.alu_op = ALU_PASS_F; c.upd_z = 1'b1; end
         OP_RL:    begin c.alu_op = ALU_RL;   c.upd_c = 1'b1; end
         OP_RR:    begin c.alu_op = ALU_RR;   c.upd_c = 1'b1; end
         OP_SWAP:  c.alu_op = ALU_SWAP;
         OP_DECSZ: begin c.alu_op = ALU_DEC;
                   c.skip_on_zero = 1'b1; end
         OP_INCSZ: begin c.alu_op = ALU_INC;
                   c.skip_on_zero = 1'b1; end
         OP_CLR:
         begin
            // Destination bit picks clear-file or the one clear-acc word
            c.alu_op = ALU_ZERO;
            if (d)
               c.upd_z = 1'b1;
            else if (w == W_CLRACC)
               c.upd_z = 1'b1;
            else
               c.illegal = 1'b1;
         end
         OP_MISC:
         begin
            c.write_acc = 1'b0;
            if (d)
               c.alu_op = ALU_PASS_W;
            else if (w == W_OPTION)
               c.load_option = 1'b1;
            else if (w == W_SLEEP)
               c.enter_standby = 1'b1;
            else if (w == W_WDTCLR)
               c.clear_watchdog = 1'b1;
            else if (w[11:3] == W_LOAD_DIRECTION_LATCH_HI && w[2:0] >= LOAD_DIRECTION_LATCH_P1)
               c.load_load_direction_latch = 1'b1;
            else if (w != W_NOP)
               c.illegal = 1'b1;
         end
         default:
         begin
            c.write_acc  = 1'b0;
            c.write_file = 1'b0;
            unique case (no)
               OP_BCLR:  begin c.alu_op = ALU_BCLR;
                         c.write_file = 1'b1; end
               OP_BSET:  begin c.alu_op = ALU_BSET;
                         c.write_file = 1'b1; end
               OP_BTSC:  c.skip_if_clear = 1'b1;
               OP_BTSS:  c.skip_if_set = 1'b1;
               OP_ANDL:  begin c.alu_op = ALU_AND; c.lit_src = 1'b1;
                         c.write_acc = 1'b1; c.upd_z = 1'b1; end
               OP_ORL:   begin c.alu_op = ALU_OR; c.lit_src = 1'b1;
                         c.write_acc = 1'b1; c.upd_z = 1'b1; end
               OP_XORL:  begin c.alu_op = ALU_XOR; c.lit_src = 1'b1;
                         c.write_acc = 1'b1; c.upd_z = 1'b1; end
               OP_LOADL: begin c.alu_op = ALU_PASS_F; c.lit_src = 1'b1;
                         c.write_acc = 1'b1; end
               OP_CALL:  c.pc_act = PC_CALL;
               OP_RETL:  begin c.pc_act = PC_RETURN;
                         c.alu_op = ALU_PASS_F; c.lit_src = 1'b1;
                         c.write_acc = 1'b1; end
               default:
                  if (w[BRANCH_HI:BRANCH_LO] == OP_LONG_BRANCH)
                     c.pc_act = PC_BRANCH;
                  else
                     c.illegal = 1'b1;
            endcase
         end
      endcase
      if (c.illegal)
      begin
         c.write_acc  = 1'b0;
         c.write_file = 1'b0;
      end
      return c;
   endfunction

   tbid_ctrl_s raw_ctrl;
   tbid_ctrl_s ctrl;
   logic       targets_timer;
   logic       writes_pc_file;
   logic       is_port_rmw;

   assign raw_ctrl = dec_word(ir);
   assign targets_timer = (fields.file_addr == TIMER_ADDR)
                          && raw_ctrl.write_file;
   // A file write to the PC register makes it a computed jump
   assign writes_pc_file = raw_ctrl.write_file
                           && (fields.file_addr == PC_ADDR);
   // Reads of a port that feed a write back to it see pin levels
   assign is_port_rmw = file_is_port_in && raw_ctrl.write_file
                        && (raw_ctrl.alu_op != ALU_PASS_W)
                        && (raw_ctrl.alu_op != ALU_ZERO);

   always_comb
   begin
      ctrl = raw_ctrl;
      ctrl.read_pins = is_port_rmw;
      ctrl.clear_prescaler = targets_timer
                             && prescaler_on_timer_in;
      if (writes_pc_file)
         ctrl.pc_act = PC_WRITE_FILE;
   end

   // ****************************************************************
   // Two-cycle decisions
   // ****************************************************************
   logic skip_taken;
   logic pc_changed;
   logic needs_second;

   assign skip_taken = (ctrl.skip_on_zero && zero_result_in)
                       || (ctrl.skip_if_clear && !tested_bit_in)
                       || (ctrl.skip_if_set && tested_bit_in);
   assign pc_changed = (ctrl.pc_act != PC_SEQ);
   assign needs_second = !second_cycle
                         && (skip_taken || pc_changed);
   assign next_second = phase_wrap ? needs_second : second_cycle;

   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         second_cycle <= 1'b0;
      else
         second_cycle <= next_second;
   end

   // Second cycle executes a flushed slot; the word is a no-op then
   always_ff @(posedge ref_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ir <= W_NOP;
      else if (phase_wrap)
         ir <= next_second ? W_NOP : instr_in;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign fetch_out         = phase_wrap && !next_second;
   assign phase_out         = phase;
   assign cycle_end_out     = phase_wrap;
   assign ctrl_out          = ctrl;
   assign fields_out        = fields;
   assign pc_bit8_clear_out = (ctrl.pc_act == PC_CALL)
                              || (ctrl.pc_act == PC_RETURN)
                              || (ctrl.pc_act == PC_WRITE_FILE);
   assign load_direction_latch_port_out     = 2'(ir[2:0] - LOAD_DIRECTION_LATCH_P1);
   assign flush_out         = second_cycle;

endmodule

// file: hw/tbid_pkg.sv
// Package for the twelve-bit instruction decoder: fields, codes, types
package tbid_pkg;

   // ****************************************************************
   // Word layout
   // ****************************************************************
   localparam int WORD_W     = 12;
   localparam int FILE_W     = 5;
   localparam int LIT_W      = 8;
   localparam int TARGET_W   = 9;
   localparam int BITNUM_W   = 3;
   localparam int BYTE_OP_HI = 11;
   localparam int BYTE_OP_LO = 6;
   localparam int DEST_POS   = 5;
   localparam int BIT_OP_HI  = 11;
   localparam int BIT_OP_LO  = 8;
   localparam int BITNUM_HI  = 7;
   localparam int BITNUM_LO  = 5;
   localparam int BRANCH_HI  = 11;
   localparam int BRANCH_LO  = 9;

   // ****************************************************************
   // Sequencing
   // ****************************************************************
   localparam int         PHASES     = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;

   // ****************************************************************
   // Byte-oriented codes (bits 11:6)
   // ****************************************************************
   localparam logic [5:0] OP_ADD   = 6'h07;
   localparam logic [5:0] OP_SUB   = 6'h02;
   localparam logic [5:0] OP_AND   = 6'h05;
   localparam logic [5:0] OP_OR    = 6'h04;
   localparam logic [5:0] OP_XOR   = 6'h06;
   localparam logic [5:0] OP_COM   = 6'h09;
   localparam logic [5:0] OP_DEC   = 6'h03;
   localparam logic [5:0] OP_INC   = 6'h0a;
   localparam logic [5:0] OP_MOV   = 6'h08;
   localparam logic [5:0] OP_DECSZ = 6'h0b;
   localparam logic [5:0] OP_INCSZ = 6'h0f;
   localparam logic [5:0] OP_RL    = 6'h0d;
   localparam logic [5:0] OP_RR    = 6'h0c;
   localparam logic [5:0] OP_SWAP  = 6'h0e;
   localparam logic [5:0] OP_MISC  = 6'h00;
   localparam logic [5:0] OP_CLR   = 6'h01;

   // ****************************************************************
   // Bit, literal and control codes (bits 11:8 or 11:9)
   // ****************************************************************
   localparam logic [3:0] OP_BCLR  = 4'h4;
   localparam logic [3:0] OP_BSET  = 4'h5;
   localparam logic [3:0] OP_BTSC  = 4'h6;
   localparam logic [3:0] OP_BTSS  = 4'h7;
   localparam logic [3:0] OP_ANDL  = 4'he;
   localparam logic [3:0] OP_ORL   = 4'hd;
   localparam logic [3:0] OP_XORL  = 4'hf;
   localparam logic [3:0] OP_LOADL = 4'hc;
   localparam logic [3:0] OP_CALL  = 4'h9;
   localparam logic [3:0] OP_RETL  = 4'h8;
   localparam logic [2:0] OP_LONG_BRANCH  = 3'h5;

   // ****************************************************************
   // Fixed words
   // ****************************************************************
   localparam logic [11:0] W_NOP    = 12'h000;
   localparam logic [11:0] W_CLRACC = 12'h040;
   localparam logic [11:0] W_OPTION = 12'h002;
   localparam logic [11:0] W_SLEEP  = 12'h003;
   localparam logic [11:0] W_WDTCLR = 12'h004;
   localparam logic [8:0]  W_LOAD_DIRECTION_LATCH_HI = 9'h000;
   localparam logic [2:0]  LOAD_DIRECTION_LATCH_P1  = 3'h5;
   localparam logic [2:0]  LOAD_DIRECTION_LATCH_P3  = 3'h7;
   localparam logic [4:0]  TIMER_ADDR = 5'h01;
   localparam logic [4:0]  PC_ADDR    = 5'h02;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [3:0] {
      ALU_PASS_F, ALU_PASS_W, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR,
      ALU_XOR, ALU_COM, ALU_DEC, ALU_INC, ALU_RL, ALU_RR, ALU_SWAP,
      ALU_ZERO, ALU_BCLR, ALU_BSET
   } tbid_alu_e;

   typedef enum logic [2:0] {
      PC_SEQ, PC_BRANCH, PC_CALL, PC_RETURN, PC_WRITE_FILE
   } tbid_pc_e;

   typedef struct packed {
      logic [4:0] file_addr;
      logic [2:0] bit_num;
      logic [7:0] literal;
      logic [8:0] target;
      logic       dest_file;
   } tbid_fields_s;

   typedef struct packed {
      tbid_alu_e  alu_op;
      logic       lit_src;
      logic       write_acc;
      logic       write_file;
      logic       upd_c;
      logic       upd_dc;
      logic       upd_z;
      logic       skip_on_zero;
      logic       skip_if_clear;
      logic       skip_if_set;
      tbid_pc_e   pc_act;
      logic       load_option;
      logic       enter_standby;
      logic       clear_watchdog;
      logic       load_load_direction_latch;
      logic       read_pins;
      logic       clear_prescaler;
      logic       illegal;
   } tbid_ctrl_s;

endpackage

// file: hw/tbid_field_split.sv
// Field extraction for one twelve-bit instruction word
module tbid_field_split
   import tbid_pkg::*;
(
   input  wire logic [11:0] word_in,
   output tbid_fields_s     fields_out
);

   assign fields_out.file_addr = word_in[FILE_W-1:0];
   assign fields_out.dest_file = word_in[DEST_POS];
   assign fields_out.bit_num   = word_in[BITNUM_HI:BITNUM_LO];
   assign fields_out.literal   = word_in[LIT_W-1:0];
   assign fields_out.target    = word_in[TARGET_W-1:0];

endmodule

// file: tb/tbid_decoder_asserts.sv
// Checker of sequencing and decode relations of the instruction decoder
module tbid_checker
   import tbid_pkg::*;
(
   input wire logic         ref_clk_in,
   input wire logic         arst_n_in,
   input wire logic         zero_result_in,
   input wire logic         tested_bit_in,
   input wire logic         fetch_out,
   input wire logic [1:0]   phase_out,
   input wire logic         cycle_end_out,
   input wire tbid_ctrl_s   ctrl_out,
   input wire tbid_fields_s fields_out,
   input wire logic         pc_bit8_clear_out,
   input wire logic         flush_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);

   wire last_ph  = (phase_out == 2'h3);
   wire seq_pc   = (ctrl_out.pc_act == PC_SEQ);
   wire skip_now = last_ph && ((ctrl_out.skip_on_zero && zero_result_in)
                  || (ctrl_out.skip_if_clear && !tested_bit_in)
                  || (ctrl_out.skip_if_set && tested_bit_in));

   a_phase_walk:
      assert property (phase_out == 2'h0 |=> phase_out == 2'h1
                       ##1 phase_out == 2'h2 ##1 last_ph ##1 !last_ph)
      else $error("phase sequence broken");
   a_cycle_end:
      assert property (cycle_end_out == last_ph)
      else $error("cycle end not on last phase");
   a_fetch_phase:
      assert property (fetch_out |-> last_ph)
      else $error("fetch outside last phase");
   a_fields_hold:
      assert property (!last_ph |=> $stable(fields_out))
      else $error("fields changed inside a cycle");
   a_skip_stall:
      assert property (skip_now |-> !fetch_out ##1 flush_out)
      else $error("skip did not add a cycle");
   a_branch_stall:
      assert property (last_ph && !seq_pc |->
                       !fetch_out ##1 flush_out[*4] ##1 !flush_out)
      else $error("program counter write not two cycles");
   a_plain_fetch:
      assert property (last_ph && seq_pc && !skip_now |-> fetch_out)
      else $error("plain instruction took a second cycle");
   a_flush_span:
      assert property ($rose(flush_out) |->
                       phase_out == 2'h0 ##0 flush_out[*4] ##1 !flush_out)
      else $error("flush cycle length wrong");
   a_pc_bit8:
      assert property (pc_bit8_clear_out == (ctrl_out.pc_act inside
                       {PC_CALL, PC_RETURN, PC_WRITE_FILE}))
      else $error("high counter bit clear wrong");
endmodule

bind tbid_decoder tbid_checker tbid_checker_inst (
   .ref_clk_in        (ref_clk_in),
   .arst_n_in         (arst_n_in),
   .zero_result_in    (zero_result_in),
   .tested_bit_in     (tested_bit_in),
   .fetch_out         (fetch_out),
   .phase_out         (phase_out),
   .cycle_end_out     (cycle_end_out),
   .ctrl_out          (ctrl_out),
   .fields_out        (fields_out),
   .pc_bit8_clear_out (pc_bit8_clear_out),
   .flush_out         (flush_out)
);

// file: tb/tbid_prog_mem.sv
// Program memory model handing out queued instruction words
module tbid_prog_mem
   import tbid_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        fetch_in,
   input  wire logic [1:0]  phase_in,
   output logic [WORD_W-1:0] word_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [WORD_W-1:0] mem [0:63];
   logic [WORD_W-1:0] last = 12'h000;
   int                wr = 0;
   int                rd = 0;
   wire               take = fetch_in && (phase_in == 2'h3) && (rd != wr);

   // Off-fetch the bus shows the inverse so a late sample is caught
   assign word_out = take ? mem[rd] : ~last;

   always @(posedge ref_clk_in)
   begin
      if (take)
      begin
         last <= mem[rd];
         rd   <= rd + 1;
      end
   end

   task automatic load(input logic [WORD_W-1:0] w);
      mem[wr] = w;
      wr++;
   endtask
endmodule

// file: tb/testbench.sv
// Self-checking testbench of the instruction decoder
`define CHK(g, e) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         num_errors++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end

module testbench
   import tbid_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   logic         ref_clk = 1'b0;
   logic         arst_n, zero_result, tested_bit, pre_on_timer, file_port;
   logic [11:0]  instr;
   logic         fetch, cycle_end, bc8, flush, bc;
   logic [1:0]   phase, load_direction_latch_port, tp;
   tbid_ctrl_s   ctrl, c;
   tbid_fields_s fields, fl;
   int           num_errors = 0;
   int           check_count = 0;

   always #5 ref_clk = ~ref_clk;

   tbid_decoder tbid_decoder_inst (
      .ref_clk_in(ref_clk), .arst_n_in(arst_n), .instr_in(instr),
      .zero_result_in(zero_result), .tested_bit_in(tested_bit),
      .prescaler_on_timer_in(pre_on_timer), .file_is_port_in(file_port),
      .fetch_out(fetch), .phase_out(phase), .cycle_end_out(cycle_end),
      .ctrl_out(ctrl), .fields_out(fields), .pc_bit8_clear_out(bc8),
      .load_direction_latch_port_out(load_direction_latch_port), .flush_out(flush));

   tbid_prog_mem tbid_prog_mem_inst (.ref_clk_in(ref_clk),
      .fetch_in(fetch), .phase_in(phase), .word_out(instr));

   // ****************************************************************
   // Tasks
   // ****************************************************************
   // m holds {two cycles, zero result, tested bit, prescaler, port}
   task automatic op(input logic [11:0] w, input logic [4:0] ef,
                     input logic [4:0] m);
      int n;
      tbid_prog_mem_inst.load(w);
      for (n = 0; n < 16 && !(phase === 2'h3 && fetch === 1'b1); n++)
         @(negedge ref_clk);
      if (n == 16)
         num_errors++;
      @(posedge ref_clk);
      zero_result  <= m[3];
      tested_bit   <= m[2];
      pre_on_timer <= m[1];
      file_port    <= m[0];
      @(negedge ref_clk);
      c  = ctrl;
      fl = fields;
      bc = bc8;
      tp = load_direction_latch_port;
      `CHK({c.upd_c, c.upd_dc, c.upd_z, c.write_acc, c.write_file}, ef)
      repeat (3) @(negedge ref_clk);
      `CHK({fetch, cycle_end}, {~m[4], 1'b1})
      if (m[4])
      begin
         @(negedge ref_clk);
         `CHK(flush, 1'b1)
         repeat (3) @(negedge ref_clk);
      end
   endtask

   task t_byte_ops;
      op(12'h1e3, 5'h1d, 5'h00);
      op(12'h083, 5'h1e, 5'h00);
      op(12'h163, 5'h05, 5'h00);
      op(12'h103, 5'h06, 5'h00);
      op(12'h1a3, 5'h05, 5'h00);
      op(12'h243, 5'h06, 5'h00);
      op(12'h0e3, 5'h05, 5'h00);
      op(12'h283, 5'h06, 5'h00);
      op(12'h223, 5'h05, 5'h00);
      op(12'h063, 5'h05, 5'h00);
      op(12'h023, 5'h01, 5'h00);
      op(12'h363, 5'h11, 5'h00);
      op(12'h303, 5'h12, 5'h00);
      op(12'h3a3, 5'h01, 5'h00);
   endtask

   task t_skips;
      op(12'h2c3, 5'h02, 5'h18);
      op(12'h2c3, 5'h02, 5'h00);
      op(12'h3e3, 5'h01, 5'h00);
      op(12'h3e3, 5'h01, 5'h18);
      op(12'h4e3, 5'h01, 5'h00);
      op(12'h543, 5'h01, 5'h04);
      op(12'h6e3, 5'h00, 5'h10);
      op(12'h6e3, 5'h00, 5'h04);
      op(12'h7e3, 5'h00, 5'h14);
      op(12'h7e3, 5'h00, 5'h00);
   endtask

   task t_fields;
      op(12'h5f5, 5'h01, 5'h00);
      `CHK({fl.bit_num, fl.file_addr}, {3'h7, 5'h15})
      op(12'h17f, 5'h05, 5'h00);
      `CHK({fl.dest_file, fl.file_addr}, {1'h1, 5'h1f})
   endtask

   task t_literal_ctrl;
      op(12'he5a, 5'h06, 5'h00);
      op(12'hd5a, 5'h06, 5'h00);
      op(12'hf5a, 5'h06, 5'h00);
      op(12'hc5a, 5'h02, 5'h00);
      `CHK(fl.literal, 8'h5a)
      op(12'h95a, 5'h00, 5'h10);
      `CHK({bc, c.pc_act}, {1'h1, PC_CALL})
      op(12'h85a, 5'h02, 5'h10);
      `CHK({bc, c.pc_act}, {1'h1, PC_RETURN})
      op(12'hb5a, 5'h00, 5'h10);
      `CHK({bc, c.pc_act, fl.target}, {1'h0, PC_BRANCH, 9'h15a})
   endtask

   task t_fixed_words;
      op(12'h000, 5'h00, 5'h00);
      op(12'h040, 5'h06, 5'h00);
      op(12'h002, 5'h00, 5'h00);
      `CHK(c.load_option, 1'b1)
      op(12'h003, 5'h00, 5'h00);
      `CHK(c.enter_standby, 1'b1)
      op(12'h004, 5'h00, 5'h00);
      `CHK(c.clear_watchdog, 1'b1)
      op(12'h001, 5'h00, 5'h00);
      `CHK({c.illegal, c.pc_act}, {1'h1, PC_SEQ})
   endtask

   task t_side_effects;
      op(12'h006, 5'h00, 5'h00);
      `CHK({c.load_load_direction_latch, tp}, 3'h5)
      op(12'h007, 5'h00, 5'h00);
      `CHK({c.load_load_direction_latch, tp}, 3'h6)
      op(12'h2a3, 5'h05, 5'h01);
      `CHK(c.read_pins, 1'b1)
      op(12'h221, 5'h05, 5'h02);
      `CHK(c.clear_prescaler, 1'b1)
      op(12'h201, 5'h06, 5'h02);
      `CHK(c.clear_prescaler, 1'b0)
      op(12'h022, 5'h01, 5'h10);
      `CHK({bc, c.pc_act}, {1'h1, PC_WRITE_FILE})
   endtask

   task complete_run;
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************************************
   // Sequence and watchdog
   // ****************************************************************
   initial
   begin
      arst_n       = 1'b0;
      zero_result  = 1'b0;
      tested_bit   = 1'b0;
      pre_on_timer = 1'b0;
      file_port    = 1'b0;
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_byte_ops();
      t_skips();
      t_fields();
      t_literal_ctrl();
      t_fixed_words();
      t_side_effects();
      complete_run();
   end

   // Whole run needs about 225 cycles
   initial
   begin
      #50000;
      num_errors++;
      complete_run();
   end
endmodule
